// ### verilog/mix_seq_pkg.sv
// constants and register map of the mix cycle sequencer
// Overview of operation
// - start, time initial mix, dose pre-wet
// - flag pre-wet done on own output
// - dry mix, main water, wet mix, then done
// - reset input returns sequence to standby
// - recipe inputs decoded binary, BCD or one-hot
// - nonzero binder timeout holds dry mix
// - binder timer from start raises alarm
// - percentage mode: additive high past threshold
// - percent reference: calculated or previous total
// - water mode: additive follows any dosing
// - legacy mode: additive high in main water
// - all-cycle mode: additive high start to done
// - two-step: split main water, repeat dry
// - average sensor at end of dry mix
// - second calibration when reading exceeds average
package mix_seq_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TIMES = 8'h04;
  localparam logic [7:0] ADR_WATER = 8'h08;
  localparam logic [7:0] ADR_PCT = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_COUNT = 8'h14;
  localparam logic [7:0] ADR_CAL = 8'h18;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [31:0] TIMES_RST = 32'h0000_0000;
  localparam logic [31:0] WATER_RST = 32'h0000_0000;
  localparam logic [6:0] PCT_RST = 7'h00;
  localparam int FMT_LSB = 0;
  localparam int MODE_LSB = 2;
  localparam int TWO_STEP_BIT = 4;
  localparam int ALARM_DIS_BIT = 5;
  localparam int CALC_BIT = 6;
  localparam int AVG_LSB = 7;
  localparam logic [1:0] FMT_BIN = 2'h0;
  localparam logic [1:0] FMT_BCD = 2'h1;
  localparam logic [1:0] FMT_ONEHOT = 2'h2;
  typedef enum logic [1:0] {
    ADD_PCT = 2'h0,
    ADD_WATER = 2'h1,
    ADD_LEGACY = 2'h2,
    ADD_ALL = 2'h3
  } additive_mode_e;
  localparam logic [15:0] PCT_SCALE = 16'h0064;
endpackage

// ### verilog/avg_if.sv
// carrier between sequencer and sensor averager
`timescale 1ns/1ps
`default_nettype none
interface avg_if;
  logic start;
  logic tick;
  logic [2:0] shift;
  logic [15:0] sample;
  logic done;
  logic [15:0] result;
  modport seq (output start, tick, shift, sample, input done, result);
  modport avg (input start, tick, shift, sample, output done, result);
endinterface
`default_nettype wire

// ### verilog/sensor_avg.sv
// averages 2**shift sensor samples taken on second ticks
`timescale 1ns/1ps
`default_nettype none
module sensor_avg (
  input wire logic i_clk,
  input wire logic i_rst_n,
  avg_if.avg bus
);
  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
    logic [22:0] acc;
    logic done;
    logic [15:0] result;
  } avg_s;
  avg_s r;
  avg_s next_r;
  logic [7:0] total;
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    total = 8'(9'h001 << bus.shift);
    if (bus.start) begin
      next_r.busy = 1'b1;
      next_r.cnt = 8'h00;
      next_r.acc = 23'h000000;
    end else if (r.busy && r.cnt == total) begin
      next_r.busy = 1'b0;
      next_r.done = 1'b1;
      next_r.result = 16'(r.acc >> bus.shift);
    end else if (r.busy && bus.tick) begin
      next_r.cnt = r.cnt + 8'h01;
      next_r.acc = r.acc + 23'(bus.sample);
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign bus.done = r.done;
  assign bus.result = r.result;
endmodule
`default_nettype wire

// ### verilog/mix_cycle_sequencer.sv
// mix cycle sequencer with wishbone registers
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module mix_cycle_sequencer
  import mix_seq_pkg::*;
#(
  parameter int SEC_CYCLES = CLK_HZ
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_start,
  input wire logic i_seq_reset,
  input wire logic i_binder_loaded,
  input wire logic i_water_pulse,
  input wire logic [7:0] i_recipe_sel,
  input wire logic [15:0] i_sensor,
  output logic o_prewet_done,
  output logic o_batch_done,
  output logic o_additive,
  output logic o_water_valve,
  output logic o_binder_alarm,
  output logic o_cal2_active,
  output logic [7:0] o_recipe
);
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_INIT_MIX = 9'h002,
    ST_PREWET = 9'h004,
    ST_WAIT_BINDER = 9'h008,
    ST_DRY_MIX = 9'h010,
    ST_AVERAGING = 9'h020,
    ST_MAIN_WATER = 9'h040,
    ST_WET_MIX = 9'h080,
    ST_DONE = 9'h100
  } state_e;
  typedef struct packed {
    state_e st;
    logic [27:0] s1;
    logic [27:0] s2;
    logic [1:0] s3;
    logic [31:0] sec_cnt;
    logic tick;
    logic [7:0] ph_s;
    logic [7:0] bind_s;
    logic bind_seen;
    logic step2;
    logic have2;
    logic avg_go;
    logic [15:0] wcnt;
    logic [15:0] last_total;
    logic [9:0] ctrl;
    logic [31:0] times;
    logic [31:0] water;
    logic [6:0] pct;
    logic [15:0] avg1;
    logic [15:0] avg2;
    logic prewet_done;
    logic batch_done;
    logic additive;
    logic valve;
    logic alarm;
    logic cal2;
    logic [7:0] recipe;
    logic ack;
    logic [31:0] dat;
  } seq_s;
  seq_s r;
  seq_s next_r;
  avg_if avg ();
  sensor_avg u_avg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(avg)
  );
  function automatic logic [7:0] decode_recipe(input logic [1:0] fmt,
                                               input logic [7:0] v);
    logic [7:0] res;
    res = 8'h00;
    if (fmt == FMT_BIN) begin
      res = v;
    end else if (fmt == FMT_BCD) begin
      if (v[7:4] < 4'ha && v[3:0] < 4'ha) begin
        res = {4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]};
      end
    end else if (fmt == FMT_ONEHOT) begin
      for (int i = 7; i >= 0; i--) begin
        if (v[i]) begin
          res = 8'(i + 1);
        end
      end
    end
    return res;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] res;
    for (int i = 0; i < 4; i++) begin
      res[i*8 +: 8] = sel[i] ? val[i*8 +: 8] : old[i*8 +: 8];
    end
    return res;
  endfunction
  logic start_rise;
  logic pulse_rise;
  logic seq_rst;
  logic binder_in;
  logic [15:0] sensor;
  logic [7:0] init_s;
  logic [7:0] dry_s;
  logic [7:0] wet_s;
  logic [7:0] bind_tmo;
  logic [15:0] prewet_amt;
  logic [15:0] main_amt;
  logic [15:0] ref_total;
  logic split_hit;
  logic pct_hit;
  logic req;
  always_comb begin
    start_rise = r.s2[0] && !r.s3[0];
    pulse_rise = r.s2[3] && !r.s3[1];
    seq_rst = r.s2[1];
    binder_in = r.s2[2];
    sensor = r.s2[27:12];
    init_s = r.times[7:0];
    dry_s = r.times[15:8];
    wet_s = r.times[23:16];
    bind_tmo = r.times[31:24];
    prewet_amt = r.water[15:0];
    main_amt = r.water[31:16];
    ref_total = r.ctrl[CALC_BIT] ? main_amt : r.last_total;
    split_hit = 23'(r.wcnt) * 23'(PCT_SCALE) >=
                23'(main_amt) * 23'(r.pct);
    pct_hit = 23'(r.wcnt) * 23'(PCT_SCALE) >=
              23'(ref_total) * 23'(r.pct);
    req = i_wb_cyc && i_wb_stb && !r.ack;
    next_r = r;
    next_r.s1 = {i_sensor, i_recipe_sel, i_water_pulse,
                 i_binder_loaded, i_seq_reset, i_start};
    next_r.s2 = r.s1;
    next_r.s3 = {r.s2[3], r.s2[0]};
    next_r.tick = r.sec_cnt == 32'(SEC_CYCLES - 1);
    next_r.sec_cnt = next_r.tick ? 32'h0 : r.sec_cnt + 32'h1;
    next_r.avg_go = 1'b0;
    next_r.recipe = decode_recipe(r.ctrl[FMT_LSB +: 2], r.s2[11:4]);
    if (r.st != ST_IDLE && r.st != ST_DONE && pulse_rise) begin
      next_r.wcnt = r.wcnt + 16'h1;
    end
    if (r.st != ST_IDLE && binder_in) begin
      next_r.bind_seen = 1'b1;
    end
    if (r.st != ST_IDLE && r.st != ST_DONE && !r.bind_seen) begin
      if (r.tick && r.bind_s != 8'hff) begin
        next_r.bind_s = r.bind_s + 8'h1;
      end
      if (bind_tmo != 8'h00 && r.bind_s >= bind_tmo &&
          !r.ctrl[ALARM_DIS_BIT]) begin
        next_r.alarm = 1'b1;
      end
    end
    if (r.tick) begin
      next_r.ph_s = r.ph_s + 8'h1;
    end
    unique case (r.st)
      ST_IDLE: begin
        if (start_rise) begin
          next_r.st = ST_INIT_MIX;
          next_r.ph_s = 8'h00;
          next_r.bind_s = 8'h00;
          next_r.bind_seen = 1'b0;
          next_r.step2 = 1'b0;
          next_r.have2 = 1'b0;
        end
      end
      ST_INIT_MIX: begin
        if (r.ph_s >= init_s) begin
          next_r.st = ST_PREWET;
          next_r.wcnt = 16'h0;
        end
      end
      ST_PREWET: begin
        if (r.wcnt >= prewet_amt) begin
          next_r.st = ST_WAIT_BINDER;
          next_r.prewet_done = 1'b1;
        end
      end
      ST_WAIT_BINDER: begin
        if (bind_tmo == 8'h00 || r.bind_seen) begin
          next_r.st = ST_DRY_MIX;
          next_r.ph_s = 8'h00;
        end
      end
      ST_DRY_MIX: begin
        if (r.ph_s >= dry_s) begin
          next_r.st = ST_AVERAGING;
          next_r.avg_go = 1'b1;
        end
      end
      ST_AVERAGING: begin
        if (avg.done) begin
          next_r.st = ST_MAIN_WATER;
          if (r.step2) begin
            next_r.avg2 = avg.result;
            next_r.have2 = 1'b1;
          end else begin
            next_r.avg1 = avg.result;
            next_r.wcnt = 16'h0;
          end
        end
      end
      ST_MAIN_WATER: begin
        if (r.ctrl[TWO_STEP_BIT] && !r.step2 && split_hit) begin
          next_r.st = ST_DRY_MIX;
          next_r.step2 = 1'b1;
          next_r.ph_s = 8'h00;
        end else if (r.wcnt >= main_amt) begin
          next_r.st = ST_WET_MIX;
          next_r.last_total = r.wcnt;
          next_r.ph_s = 8'h00;
        end
      end
      ST_WET_MIX: begin
        if (r.ph_s >= wet_s) begin
          next_r.st = ST_DONE;
          next_r.batch_done = 1'b1;
        end
      end
      ST_DONE: begin
      end
    endcase
    if (seq_rst) begin
      next_r.st = ST_IDLE;
      next_r.prewet_done = 1'b0;
      next_r.batch_done = 1'b0;
      next_r.bind_s = 8'h00;
      next_r.bind_seen = 1'b0;
      next_r.alarm = 1'b0;
      next_r.avg_go = 1'b0;
    end
    next_r.valve = next_r.st == ST_PREWET || next_r.st == ST_MAIN_WATER;
    unique case (additive_mode_e'(r.ctrl[MODE_LSB +: 2]))
      ADD_PCT: next_r.additive = next_r.st == ST_MAIN_WATER &&
                                 pct_hit;
      ADD_WATER: next_r.additive = next_r.valve;
      ADD_LEGACY: next_r.additive = next_r.st == ST_MAIN_WATER;
      ADD_ALL: next_r.additive = next_r.st != ST_IDLE &&
                                 next_r.st != ST_DONE;
    endcase
    next_r.cal2 = r.ctrl[TWO_STEP_BIT] && r.have2 &&
                  sensor > r.avg2;
    next_r.ack = req;
    next_r.dat = 32'h0;
    if (r.ack && i_wb_cyc && i_wb_stb && i_wb_we) begin
      unique case (i_wb_adr)
        ADR_CTRL: next_r.ctrl = 10'(merge(32'(r.ctrl), i_wb_dat, i_wb_sel));
        ADR_TIMES: next_r.times = merge(r.times, i_wb_dat, i_wb_sel);
        ADR_WATER: next_r.water = merge(r.water, i_wb_dat, i_wb_sel);
        ADR_PCT: next_r.pct = 7'(merge(32'(r.pct), i_wb_dat, i_wb_sel));
        default: begin
        end
      endcase
    end else if (req && !i_wb_we) begin
      unique case (i_wb_adr)
        ADR_CTRL: next_r.dat = 32'(r.ctrl);
        ADR_TIMES: next_r.dat = r.times;
        ADR_WATER: next_r.dat = r.water;
        ADR_PCT: next_r.dat = 32'(r.pct);
        ADR_STATUS: next_r.dat = {12'h0, r.step2, r.alarm, r.bind_seen,
                                  r.recipe, r.st};
        ADR_COUNT: next_r.dat = {r.wcnt, r.last_total};
        ADR_CAL: next_r.dat = {r.avg2, r.avg1};
        default: next_r.dat = 32'h0;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= CTRL_RST;
      r.times <= TIMES_RST;
      r.water <= WATER_RST;
      r.pct <= PCT_RST;
    end else begin
      r <= next_r;
    end
  end
  assign avg.start = r.avg_go;
  assign avg.tick = r.tick;
  assign avg.shift = r.ctrl[AVG_LSB +: 3];
  assign avg.sample = sensor;
  assign o_wb_ack = r.ack;
  assign o_wb_dat = r.dat;
  assign o_prewet_done = r.prewet_done;
  assign o_batch_done = r.batch_done;
  assign o_additive = r.additive;
  assign o_water_valve = r.valve;
  assign o_binder_alarm = r.alarm;
  assign o_cal2_active = r.cal2;
  assign o_recipe = r.recipe;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_seq_reset_idle: assert property (r.s2[1] |=> r.st == ST_IDLE &&
    !o_batch_done && !o_prewet_done)
    else $error("sequencer not idle after reset input");
  a_reset_clears_alarm: assert property (r.s2[1] |=> !o_binder_alarm &&
    r.bind_s == 8'h00)
    else $error("binder timer not cleared by reset");
  a_prewet_flag: assert property (r.st == ST_PREWET &&
    r.wcnt >= r.water[15:0] && !r.s2[1] |=> o_prewet_done)
    else $error("pre-wet completion not flagged");
  a_binder_hold: assert property (r.st == ST_WAIT_BINDER &&
    r.times[31:24] != 8'h00 && !r.bind_seen |=> r.st != ST_DRY_MIX)
    else $error("dry mix started without binder");
  a_done_after_wet: assert property ($rose(o_batch_done) |->
    $past(r.st) == ST_WET_MIX)
    else $error("batch done not after wet mix");
  a_all_mode_busy: assert property (r.ctrl[3:2] == 2'h3 &&
    r.st inside {ST_DRY_MIX, ST_WET_MIX} ##1 r.ctrl[3:2] == 2'h3 &&
    r.st inside {ST_DRY_MIX, ST_WET_MIX} |-> o_additive)
    else $error("all-cycle additive dropped mid cycle");
  a_legacy_mode: assert property (r.ctrl[3:2] == 2'h2 &&
    $stable(r.ctrl) |-> o_additive == (r.st == ST_MAIN_WATER))
    else $error("legacy additive wrong");
  a_water_mode: assert property (r.ctrl[3:2] == 2'h1 &&
    $stable(r.ctrl) |-> o_additive == o_water_valve)
    else $error("water additive does not follow valve");
  a_alarm_cause: assert property ($rose(o_binder_alarm) |->
    $past(r.times[31:24]) != 8'h00 && !$past(r.ctrl[5]))
    else $error("binder alarm without timeout");
  a_two_step_repeat: assert property (r.st == ST_MAIN_WATER
    ##1 r.st == ST_DRY_MIX |-> r.step2 && r.ctrl[4])
    else $error("dry mix repeated without two-step");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  c_full_batch: cover property ($rose(o_batch_done));
  c_two_step: cover property (r.step2 && r.st == ST_DRY_MIX);
  c_alarm: cover property ($rose(o_binder_alarm));
  c_cal2: cover property ($rose(o_cal2_active));
endmodule
`default_nettype wire

// ### dv/plant_model.sv
// behavioural model of the plant batch controller pins
`timescale 1ns/1ps
`default_nettype none
module plant_model #(
  parameter int SEC_CYCLES = 20,
  parameter int BINDER_DLY = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_start,
  input wire logic i_req_reset,
  input wire logic i_binder_en,
  input wire logic i_prewet_done,
  input wire logic i_water_valve,
  output logic o_start,
  output logic o_seq_reset,
  output logic o_binder_loaded,
  output logic o_water_pulse
);
  int rst_cnt;
  int guard;
  int bdly;
  logic [1:0] phase;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_cnt <= 0;
      guard <= 0;
      bdly <= 0;
      phase <= 2'h0;
      o_start <= 1'b0;
      o_seq_reset <= 1'b0;
      o_binder_loaded <= 1'b0;
      o_water_pulse <= 1'b0;
    end else begin
      // reset pulse, then ten seconds before start may rise
      if (i_req_reset) begin
        rst_cnt <= 4;
        guard <= 10 * SEC_CYCLES;
      end else if (rst_cnt > 0) begin
        rst_cnt <= rst_cnt - 1;
      end else if (guard > 0) begin
        guard <= guard - 1;
      end
      o_seq_reset <= i_req_reset || (rst_cnt != 0);
      o_start <= i_req_start && !i_req_reset && rst_cnt == 0 &&
                 guard == 0;
      // binder goes in only after pre-wet is flagged
      if (o_seq_reset) begin
        bdly <= 0;
        o_binder_loaded <= 1'b0;
      end else if (i_prewet_done && i_binder_en) begin
        if (bdly < BINDER_DLY) begin
          bdly <= bdly + 1;
        end else begin
          o_binder_loaded <= 1'b1;
        end
      end
      // flow meter: one pulse per four cycles of open valve
      phase <= i_water_valve ? phase + 2'h1 : 2'h0;
      o_water_pulse <= i_water_valve & phase[1];
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the mix cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mix_seq_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00, rsel = 8'h00, recipe;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [15:0] sensor = 16'h0100;
  logic ack, start, sreset, binder, pulse, prewet, done, add, valve;
  logic alarm, cal2;
  logic req_start = 0, req_reset = 0, ben = 0, track = 0, vprev = 0;
  logic [7:0] sv [4] = '{8'hff, 8'h99, 8'h80, 8'h2a};
  logic [7:0] ex [4] = '{8'hff, 8'h63, 8'h08, 8'h00};
  logic [7:0] regs [4] = '{ADR_CTRL, ADR_TIMES, ADR_WATER, ADR_PCT};
  int mismatches = 0, checks = 0, n_pre, n_main, n_mlo, n_rise;

  always #12.5 clk = ~clk;

  mix_cycle_sequencer #(.SEC_CYCLES(20)) i_mix_cycle_sequencer (
    .i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_start(start),
    .i_seq_reset(sreset), .i_binder_loaded(binder),
    .i_water_pulse(pulse), .i_recipe_sel(rsel), .i_sensor(sensor),
    .o_prewet_done(prewet), .o_batch_done(done), .o_additive(add),
    .o_water_valve(valve), .o_binder_alarm(alarm),
    .o_cal2_active(cal2), .o_recipe(recipe));

  plant_model #(.SEC_CYCLES(20), .BINDER_DLY(8)) i_plant_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_req_start(req_start),
    .i_req_reset(req_reset), .i_binder_en(ben), .i_prewet_done(prewet),
    .i_water_valve(valve), .o_start(start), .o_seq_reset(sreset),
    .o_binder_loaded(binder), .o_water_pulse(pulse));

  // additive activity seen while water flows
  always @(posedge clk) begin
    if (track && valve === 1'b1) begin
      if (prewet !== 1'b1 && add === 1'b1) n_pre++;
      if (prewet === 1'b1 && add === 1'b1) n_main++;
      if (prewet === 1'b1 && add === 1'b0) n_mlo++;
      if (prewet === 1'b1 && vprev !== 1'b1) n_rise++;
    end
    vprev = valve;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task expire(input string msg);
    mismatches++;
    $display("BAD %0t timeout %s", $time, msg);
    end_of_test();
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) expire("bus");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task plant_reset;
    @(posedge clk);
    req_start <= 1'b0;
    req_reset <= 1'b1;
    @(posedge clk);
    req_reset <= 1'b0;
  endtask

  task launch(input logic [31:0] ctrl, input logic b);
    wb(1'b1, ADR_CTRL, ctrl, 4'hf);
    ben <= b;
    plant_reset();
    repeat (8) @(posedge clk);
    req_start <= 1'b1;
    n_pre = 0;
    n_main = 0;
    n_mlo = 0;
    n_rise = 0;
    track = 1'b1;
  endtask

  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'b1) expire("batch");
    track = 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0, 4'hf);
      check(q === 32'h0, "register reset value");
    end
    wb(1'b1, 8'h1c, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h1c, 32'h0, 4'hf);
    check(q === 32'h0, "unmapped read");
    wb(1'b1, ADR_STATUS, 32'h0, 4'hf);
    wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
    check(q[0] === 1'b1, "status idle after write");
    wb(1'b1, ADR_CTRL, 32'hffff_ffff, 4'h1);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    check(q === 32'h0000_00ff, "byte lane write");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADR_CTRL, 32'(i), 4'hf);
      rsel <= sv[i];
      repeat (6) @(posedge clk);
      check(recipe === ex[i], "recipe decode");
    end
    wb(1'b1, ADR_TIMES, 32'h0a01_0101, 4'hf);
    wb(1'b1, ADR_WATER, 32'h0008_0002, 4'hf);
    wb(1'b1, ADR_PCT, 32'h0000_0032, 4'hf);
    for (int m = 0; m < 4; m++) begin
      launch(32'h40 | 32'(m << 2), 1'b1);
      wait_done();
      check(prewet === 1'b1, "pre-wet flag");
      check(add === 1'b0, "additive after done");
      check(alarm === 1'b0, "spurious alarm");
      check((n_pre > 0) === (m == 1 || m == 3), "prewet additive");
      check(n_main > 0, "additive in main water");
      check(n_rise == 1, "single main dose");
      if (m == 0) check(n_mlo > 0, "additive before threshold");
      wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
      check(q[8] === 1'b1, "done state");
    end
    launch(32'h0000_0050, 1'b1);
    wait_done();
    check(n_rise == 2, "two dose portions");
    wb(1'b0, ADR_CAL, 32'h0, 4'hf);
    check(q === 32'h0100_0100, "dry averages");
    sensor <= 16'h0200;
    repeat (8) @(posedge clk);
    check(cal2 === 1'b1, "second calibration");
    wb(1'b1, ADR_TIMES, 32'h0201_0101, 4'hf);
    for (int d = 0; d < 2; d++) begin
      launch(32'h0c | 32'(d << 5), 1'b0);
      repeat (400) @(posedge clk);
      check(done === 1'b0, "dry mix held");
      wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
      check(q[3] === 1'b1, "waiting for binder");
      check(alarm === (d == 0), "binder alarm");
      check(add === 1'b1, "busy indication");
      track = 1'b0;
      plant_reset();
      repeat (8) @(posedge clk);
      check({prewet, done, alarm, add} === 4'h0, "outputs cleared");
      wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
      check(q[0] === 1'b1, "standby");
    end
    end_of_test();
  end
endmodule
`default_nettype wire
